// ==== hdl/ocf_pkg.sv ====
// package for the over-current fault response controller
package ocf_pkg;
   // response code values, bits 7:6 of the action byte
   localparam logic [1:0] OCF_RESP_IGNORE  = 2'h0;
   localparam logic [1:0] OCF_RESP_LV      = 2'h1;
   localparam logic [1:0] OCF_RESP_DELAY   = 2'h2;
   localparam logic [1:0] OCF_RESP_DISABLE = 2'h3;
   // field positions in the action byte
   localparam int OCF_RESP_MSB  = 7;
   localparam int OCF_RESP_LSB  = 6;
   localparam int OCF_RETRY_MSB = 5;
   localparam int OCF_RETRY_LSB = 3;
   localparam int OCF_TIME_MSB  = 2;
   localparam int OCF_TIME_LSB  = 0;
   // retry field special values
   localparam logic [2:0] OCF_RETRY_NONE    = 3'h0;
   localparam logic [2:0] OCF_RETRY_FOREVER = 3'h7;
   // value after reset of the action byte (ignore, no retry, x1)
   localparam logic [7:0] OCF_ACTION_RST = 8'h00;
   // default time unit in clock cycles (10 us at 100 MHz)
   localparam int OCF_UNIT_NS       = 10000;
   localparam int OCF_CLK_PERIOD_NS = 10;
   localparam int OCF_UNIT_CYC      = (OCF_UNIT_NS + OCF_CLK_PERIOD_NS - 1) / OCF_CLK_PERIOD_NS;
   localparam int OCF_UNIT_W        = 16;
   localparam int OCF_TIMER_W       = 8;
endpackage : ocf_pkg

// ==== hdl/ocf_unit_tick.sv ====
// time unit divider: one-cycle tick every unit_cycles clocks
`timescale 1ns/1ps
module ocf_unit_tick
   import ocf_pkg::*;
#(
   parameter int UNIT_W = OCF_UNIT_W
)(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              run,
   input  wire logic [UNIT_W-1:0] unit_cycles,
   output logic                   tick
);
   typedef struct packed {
      logic [UNIT_W-1:0] cnt;
      logic              tick;
   } ocf_div_t;

   ocf_div_t st_reg;
   ocf_div_t st_next;

   // restart from zero whenever the timer is idle so each delay starts aligned
   always_comb
   begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (!run)
      begin
         st_next.cnt = '0;
      end
      else if (st_reg.cnt + 1'b1 >= unit_cycles)
      begin
         st_next.cnt  = '0;
         st_next.tick = 1'b1;
      end
      else
      begin
         st_next.cnt = UNIT_W'(st_reg.cnt + 1'b1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign tick = st_reg.tick;
endmodule // ocf_unit_tick

// ==== hdl/ocf_ctrl.sv ====
// over-current fault response controller: action byte, state machine, retry logic
`timescale 1ns/1ps
module ocf_ctrl
   import ocf_pkg::*;
#(
   parameter int UNIT_W = OCF_UNIT_W
)(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              action_wr,
   input  wire logic [7:0]        action_wdata,
   output logic       [7:0]       action_rdata,
   input  wire logic [UNIT_W-1:0] unit_cycles,
   input  wire logic              oc_detect,
   input  wire logic              lv_detect,
   input  wire logic              fault_clear,
   output logic                   output_enable,
   output logic                   current_limit,
   output logic                   oc_fault_flag,
   output logic                   host_alert,
   output logic                   latched_off
);
   typedef enum logic [4:0] {
      S_RUN   = 5'b00001,
      S_LIMIT = 5'b00010,
      S_OFF   = 5'b00100,
      S_WAIT  = 5'b01000,
      S_LATCH = 5'b10000
   } ocf_state_t;

   typedef struct packed {
      ocf_state_t             state;
      logic [7:0]             action;
      logic [2:0]             retries;
      logic [OCF_TIMER_W-1:0] units;
      logic                   flag;
   } ocf_st_t;

   ocf_st_t st_reg;
   ocf_st_t st_next;
   logic    tick;
   logic    timing;

   logic [1:0] resp;
   logic [2:0] retry_cfg;
   logic [2:0] time_cfg;
   assign resp      = st_reg.action[OCF_RESP_MSB:OCF_RESP_LSB];
   assign retry_cfg = st_reg.action[OCF_RETRY_MSB:OCF_RETRY_LSB];
   assign time_cfg  = st_reg.action[OCF_TIME_MSB:OCF_TIME_LSB];

   // power-of-two multiplier of the time unit
   function automatic logic [OCF_TIMER_W-1:0] mult_of(input logic [2:0] code);
      mult_of = OCF_TIMER_W'(9'h001 << code);
   endfunction

   // counter runs only in the two timed states
   assign timing = (st_reg.state == S_LIMIT && resp == OCF_RESP_DELAY) || (st_reg.state == S_WAIT);

   ocf_unit_tick #(
      .UNIT_W(UNIT_W)
   ) u_tick (
      .ref_clk     (ref_clk),
      .rst_n       (rst_n),
      .run         (timing),
      .unit_cycles (unit_cycles),
      .tick        (tick)
   );

   // next-state logic
   always_comb
   begin
      st_next = st_reg;
      if (oc_detect)
         st_next.flag = 1'b1;
      else if (fault_clear)
         st_next.flag = 1'b0;
      if (timing && tick)
         st_next.units = OCF_TIMER_W'(st_reg.units + 1'b1);
      unique case (st_reg.state)
         S_RUN:
         begin
            st_next.units = '0;
            if (oc_detect)
            begin
               if (resp == OCF_RESP_DISABLE)
                  st_next.state = S_OFF;
               else if (resp == OCF_RESP_LV && lv_detect)
                  st_next.state = S_OFF;
               else
                  st_next.state = S_LIMIT;
            end
         end
         S_LIMIT:
         begin
            if (!oc_detect)
               st_next.state = S_RUN;
            else if (resp == OCF_RESP_LV && lv_detect)
               st_next.state = S_OFF;
            else if (resp == OCF_RESP_DISABLE)
               st_next.state = S_OFF;
            else if (resp == OCF_RESP_DELAY && tick && (st_reg.units + 1'b1) >= mult_of(time_cfg))
               st_next.state = S_OFF;
         end
         S_OFF:
         begin
            st_next.units = '0;
            if (resp == OCF_RESP_DISABLE)
            begin
               if (!oc_detect)
                  st_next.state = S_RUN;
            end
            else if (retry_cfg == OCF_RETRY_NONE)
               st_next.state = S_LATCH;
            else if (retry_cfg == OCF_RETRY_FOREVER)
               st_next.state = S_WAIT;
            else if (st_reg.retries != 3'h0)
            begin
               st_next.retries = st_reg.retries - 3'h1;
               st_next.state   = S_WAIT;
            end
            else
               st_next.state = S_LATCH;
         end
         S_WAIT:
         begin
            if (tick && (st_reg.units + 1'b1) >= mult_of(time_cfg))
            begin
               st_next.units = '0;
               st_next.state = S_RUN;
            end
         end
         S_LATCH:
         begin
            if (fault_clear)
               st_next.state = S_RUN;
         end
      endcase
      // rewrite or clear reloads the retry budget
      if (fault_clear || action_wr)
         st_next.retries = action_wr ? action_wdata[OCF_RETRY_MSB:OCF_RETRY_LSB] : retry_cfg;
      if (action_wr)
         st_next.action = action_wdata;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_reg.state   <= S_RUN;
         st_reg.action  <= OCF_ACTION_RST;
         st_reg.retries <= OCF_ACTION_RST[OCF_RETRY_MSB:OCF_RETRY_LSB];
         st_reg.units   <= '0;
         st_reg.flag    <= 1'b0;
      end
      else
         st_reg <= st_next;
   end

   // outputs straight from state
   assign action_rdata  = st_reg.action;
   assign output_enable = (st_reg.state == S_RUN) || (st_reg.state == S_LIMIT);
   assign current_limit = (st_reg.state == S_LIMIT);
   assign oc_fault_flag = st_reg.flag;
   assign host_alert    = st_reg.flag;
   assign latched_off   = (st_reg.state == S_LATCH);

   a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
      oc_detect |=> oc_fault_flag) else $error("fault flag not set");
   a_ignore_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (resp == OCF_RESP_IGNORE && !action_wr && st_reg.state == S_LIMIT && oc_detect) |=> output_enable)
      else $error("ignore mode shut down");
   a_lv_shut: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (resp == OCF_RESP_LV && !action_wr && st_reg.state == S_LIMIT && oc_detect && lv_detect) |=> !output_enable)
      else $error("low voltage did not shut down");
   a_lv_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (resp == OCF_RESP_LV && !action_wr && st_reg.state == S_LIMIT && oc_detect && !lv_detect) |=> current_limit)
      else $error("limit lost above threshold");
   a_disable_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (resp == OCF_RESP_DISABLE && !action_wr && st_reg.state == S_OFF && oc_detect) |=> !output_enable)
      else $error("output on during fault");
   a_disable_resume: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (resp == OCF_RESP_DISABLE && !action_wr && st_reg.state == S_OFF && !oc_detect) |=> output_enable)
      else $error("output did not resume");
   a_no_retry: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_OFF && resp != OCF_RESP_DISABLE && retry_cfg == OCF_RETRY_NONE && !action_wr)
      |=> latched_off) else $error("restart with zero retries");
   a_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (latched_off && !fault_clear) |=> latched_off) else $error("latch left without clear");
   a_forever: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_OFF && resp != OCF_RESP_DISABLE && retry_cfg == OCF_RETRY_FOREVER && !action_wr)
      |=> st_reg.state == S_WAIT) else $error("continuous retry stopped");
   a_retry_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_OFF && resp != OCF_RESP_DISABLE && retry_cfg != OCF_RETRY_NONE
       && retry_cfg != OCF_RETRY_FOREVER && !action_wr && !fault_clear && st_reg.retries != 3'h0)
      |=> st_reg.retries == $past(st_reg.retries) - 3'h1) else $error("retry count wrong");
   a_wait_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_WAIT && !tick) |=> !output_enable) else $error("restart before wait");
   // fixed table point, so a broken shift in the function shows up
   a_mult_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (time_cfg == 3'h4) |-> mult_of(time_cfg) == 8'h10) else $error("multiplier map wrong");
   a_delay_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (resp == OCF_RESP_DELAY && !action_wr && st_reg.state == S_LIMIT && oc_detect && tick
       && (st_reg.units + 1'b1) >= mult_of(time_cfg)) |=> !output_enable)
      else $error("delay expiry did not shut down");
   a_mult_top: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (time_cfg == 3'h7) |-> mult_of(time_cfg) == 8'h80) else $error("top multiplier wrong");

   // lowest of the long multipliers
   a_mult_mid: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (time_cfg == 3'h5) |-> mult_of(time_cfg) == 8'h20) else $error("mid multiplier wrong");

   // a clear without a new fault drops the flag
   a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!oc_detect && fault_clear) |=> !oc_fault_flag) else $error("fault flag not cleared");

   // flag stays until the host clears it
   a_flag_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (oc_fault_flag && !fault_clear) |=> oc_fault_flag) else $error("fault flag dropped");

   // code 00 enters limiting on a fresh fault
   a_ignore_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_RUN && resp == OCF_RESP_IGNORE && oc_detect && !action_wr) |=> current_limit)
      else $error("ignore mode did not limit");

   // code 00 pays no heed to low voltage
   a_ignore_lv: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (resp == OCF_RESP_IGNORE && !action_wr && st_reg.state == S_LIMIT && oc_detect && lv_detect)
      |=> current_limit) else $error("ignore mode reacted to voltage");

   // code 01 with voltage already low goes straight off
   a_lv_direct: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_RUN && resp == OCF_RESP_LV && oc_detect && lv_detect && !action_wr)
      |=> !output_enable) else $error("low voltage entry not off");

   // code 01 with voltage good limits first
   a_lv_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_RUN && resp == OCF_RESP_LV && oc_detect && !lv_detect && !action_wr)
      |=> current_limit) else $error("low voltage mode did not limit");

   // code 01 leaves limiting when the fault goes
   a_lv_exit: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (resp == OCF_RESP_LV && !action_wr && st_reg.state == S_LIMIT && !oc_detect)
      |=> (output_enable && !current_limit)) else $error("limit held after fault");

   // code 10 keeps limiting until a unit tick can end the delay
   a_delay_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (resp == OCF_RESP_DELAY && !action_wr && st_reg.state == S_LIMIT && oc_detect && !tick)
      |=> current_limit) else $error("delay cut short");

   // code 10 carries on normally once limiting ends
   a_delay_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (resp == OCF_RESP_DELAY && !action_wr && st_reg.state == S_LIMIT && !oc_detect)
      |=> (output_enable && !current_limit)) else $error("delay mode did not resume");

   // code 11 switches off on a fresh fault
   a_disable_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_RUN && resp == OCF_RESP_DISABLE && oc_detect && !action_wr)
      |=> !output_enable) else $error("disable mode stayed on");

   // code 11 never latches, whatever the retry field says
   a_disable_nolatch: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_OFF && resp == OCF_RESP_DISABLE && oc_detect && !action_wr)
      |=> !latched_off) else $error("disable mode latched");

   // a clear releases the latch
   a_latch_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (latched_off && fault_clear) |=> output_enable) else $error("latch not released");

   // budget spent: give up and stay off
   a_retry_last: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_OFF && resp != OCF_RESP_DISABLE && retry_cfg != OCF_RETRY_NONE
       && retry_cfg != OCF_RETRY_FOREVER && !action_wr && !fault_clear && st_reg.retries == 3'h0)
      |=> latched_off) else $error("restart beyond budget");

   // wait over: restart attempt
   a_wait_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (st_reg.state == S_WAIT && tick && (st_reg.units + 1'b1) >= mult_of(time_cfg))
      |=> output_enable) else $error("no restart after wait");

   // a rewrite reloads the retry budget from the new byte
   a_retry_reload: assert property (@(posedge ref_clk) disable iff (!rst_n)
      action_wr |=> st_reg.retries == $past(action_wdata[OCF_RETRY_MSB:OCF_RETRY_LSB]))
      else $error("retry budget not reloaded");
endmodule // ocf_ctrl

// ==== verif/ocf_host_model.sv ====
// host model: issues action byte writes and fault clears
`timescale 1ns/1ps
module ocf_host_model
(
   input  wire logic ref_clk,
   output logic      action_wr,
   output logic [7:0] action_wdata,
   output logic      fault_clear
);
   // idle host: no write, data bus shows a pattern, no clear
   initial
   begin
      action_wr = 1'b0;
      action_wdata = 8'ha5;
      fault_clear = 1'b0;
   end
   // one-cycle write; data inverted after so a stale byte never looks valid
   task write_action(input logic [7:0] d);
      @(negedge ref_clk);
      action_wr = 1'b1;
      action_wdata = d;
      @(negedge ref_clk);
      action_wr = 1'b0;
      action_wdata = ~d;
   endtask
   // one-cycle fault clear pulse
   task clear_fault();
      @(negedge ref_clk);
      fault_clear = 1'b1;
      @(negedge ref_clk);
      fault_clear = 1'b0;
   endtask
endmodule // ocf_host_model

// ==== verif/testbench.sv ====
// self-checking bench for the over-current fault response controller
`timescale 1ns/1ps
module testbench;
   import ocf_pkg::*;
   localparam int U = 4;
   logic ref_clk, rst_n, action_wr, fault_clear, oc_detect, lv_detect;
   logic output_enable, current_limit, oc_fault_flag, host_alert, latched_off;
   logic [7:0] action_wdata, action_rdata;
   logic [OCF_UNIT_W-1:0] unit_cycles;
   int n_fail, num_checks, cyc, c, rs, mo;
   ocf_ctrl i_ocf_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .action_wr(action_wr), .action_wdata(action_wdata),
      .action_rdata(action_rdata), .unit_cycles(unit_cycles), .oc_detect(oc_detect), .lv_detect(lv_detect),
      .fault_clear(fault_clear), .output_enable(output_enable), .current_limit(current_limit),
      .oc_fault_flag(oc_fault_flag), .host_alert(host_alert), .latched_off(latched_off));
   ocf_host_model i_ocf_host_model (.ref_clk(ref_clk), .action_wr(action_wr), .action_wdata(action_wdata),
      .fault_clear(fault_clear));
   task chk(input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin $display("MISMATCH %0t exp %h got %h", $time, e, g); n_fail++; end
   endtask
   task chk_win(input int lo, input int hi, input int g);
      num_checks++;
      if (g < lo || g > hi) begin $display("MISMATCH %0t exp %h..%h got %h", $time, lo, hi, g); n_fail++; end
   endtask
   task cycles(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // bounded wait for the output to reach a level
   task wait_oe(input logic v, output int n);
      n = 0;
      while (output_enable !== v && n < 3000) begin @(negedge ref_clk); n++; end
   endtask
   // drop the fault, clear it and wait for the output to return
   task recover();
      oc_detect = 1'b0;
      lv_detect = 1'b0;
      i_ocf_host_model.clear_fault();
      wait_oe(1'b1, c);
   endtask
   task t_reset();
      chk(8'h08, {output_enable, current_limit, oc_fault_flag, latched_off});
      chk(OCF_ACTION_RST, action_rdata);
      i_ocf_host_model.write_action(8'h5a);
      chk(8'h5a, action_rdata);
      $display("test reset done");
   endtask
   // voltage held low too: code 00 must ignore it
   task t_ignore();
      i_ocf_host_model.write_action({OCF_RESP_IGNORE, 3'h1, 3'h0});
      oc_detect = 1'b1;
      lv_detect = 1'b1;
      cycles(3);
      chk(8'h0f, {output_enable, current_limit, oc_fault_flag, host_alert});
      cycles(300);
      chk(8'h06, {output_enable, current_limit, latched_off});
      recover();
      chk(8'h00, {current_limit, oc_fault_flag});
      $display("test ignore done");
   endtask
   task t_lowv();
      i_ocf_host_model.write_action({OCF_RESP_LV, OCF_RETRY_NONE, 3'h0});
      oc_detect = 1'b1;
      cycles(3);
      chk(8'h03, {output_enable, current_limit});
      lv_detect = 1'b1;
      cycles(100);
      chk(8'h01, {output_enable, latched_off});
      oc_detect = 1'b0;
      lv_detect = 1'b0;
      cycles(50);
      chk(8'h01, {output_enable, latched_off});
      recover();
      chk(8'h02, {output_enable, latched_off});
      $display("test low voltage done");
   endtask
   task t_disable();
      i_ocf_host_model.write_action({OCF_RESP_DISABLE, OCF_RETRY_NONE, 3'h0});
      oc_detect = 1'b1;
      cycles(60);
      chk(8'h00, {output_enable, latched_off});
      oc_detect = 1'b0;
      wait_oe(1'b1, c);
      chk_win(0, 3, c);
      $display("test disable done");
   endtask
   // limiting span must follow the power-of-two multiplier
   task t_delay();
      for (int t = 0; t < 8; t++) begin
         i_ocf_host_model.write_action({OCF_RESP_DELAY, OCF_RETRY_NONE, t[2:0]});
         oc_detect = 1'b1;
         cycles(2);
         chk(8'h01, current_limit);
         wait_oe(1'b0, c);
         chk_win((U << t) - U - 2, (U << t) + U + 2, c);
         cycles(3);
         chk(8'h01, latched_off);
         recover();
      end
      i_ocf_host_model.write_action({OCF_RESP_DELAY, OCF_RETRY_NONE, 3'h7});
      oc_detect = 1'b1;
      cycles(20);
      oc_detect = 1'b0;
      cycles(600);
      chk(8'h02, {output_enable, latched_off});
      $display("test delay done");
   endtask
   // counts returns to on, and the shortest off span, until latched
   task count_rs(input int lim);
      int off;
      logic prev;
      rs = 0;
      off = 0;
      mo = 100000;
      prev = output_enable;
      repeat (lim) begin
         @(negedge ref_clk);
         if (output_enable === 1'b0) off++;
         if (output_enable === 1'b1 && prev === 1'b0) begin rs++; if (off < mo) mo = off; off = 0; end
         prev = output_enable;
         if (latched_off === 1'b1) break;
      end
   endtask
   task t_retry();
      int tbl[3] = '{1, 2, 6};
      foreach (tbl[i]) begin
         i_ocf_host_model.write_action({OCF_RESP_DELAY, tbl[i][2:0], 3'h0});
         oc_detect = 1'b1;
         count_rs(2000);
         chk(tbl[i], rs);
         chk_win(U, 3 * U + 4, mo);
         recover();
      end
      i_ocf_host_model.write_action({OCF_RESP_DELAY, OCF_RETRY_FOREVER, 3'h0});
      oc_detect = 1'b1;
      count_rs(1500);
      chk_win(10, 1500, rs);
      chk(8'h00, latched_off);
      recover();
      $display("test retry done");
   endtask
   task test_done();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // free-running clock, 10 ns period
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // hang guard: well above the expected run length
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 60000) begin n_fail++; test_done(); end
   end
   initial
   begin
      n_fail = 0;
      num_checks = 0;
      cyc = 0;
      rst_n = 1'b0;
      oc_detect = 1'b0;
      lv_detect = 1'b0;
      unit_cycles = U;
      cycles(4);
      rst_n = 1'b1;
      cycles(1);
      t_reset();
      t_ignore();
      t_lowv();
      t_disable();
      t_delay();
      t_retry();
      test_done();
   end
endmodule // testbench
